// ### tpg_pkg.sv
// Shared types and constants of the serializer test pattern generator
package tpg_pkg;
    localparam int WORD_W = 14;
    localparam int REG_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam logic [13:0] MIN_CODE = 14'h0000;
    localparam logic [13:0] MAX_CODE = 14'h3fff;
    localparam logic [13:0] LFSR_TAPS = 14'h3500;
    localparam logic [13:0] LFSR_RESET = 14'h0001;
    localparam int HI_FIXED_W = 6;
    localparam int HI_LINK_W = 8;

    typedef enum logic [2:0] {
        MODE_FIXED = 3'h0,
        MODE_HGRAD = 3'h1,
        MODE_VGRAD = 3'h2,
        MODE_LATTICE = 3'h3,
        MODE_STRIPE = 3'h4,
        MODE_LINK_SYNC = 3'h5,
        MODE_LINK_ASYNC = 3'h6,
        MODE_RESERVED = 3'h7
    } pattern_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_LINE,
        ST_RUN
    } gen_state_t;

    typedef struct packed {
        logic [7:0] value_hi;
        logic [7:0] value_lo;
        logic [13:0] step;
        logic [15:0] pitch;
        logic [15:0] start_len;
        logic [15:0] width;
    } pattern_cfg_t;

    typedef struct packed {
        logic [13:0] ch1;
        logic [13:0] ch2;
    } pixel_pair_t;
endpackage : tpg_pkg

// ### pixel_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module pixel_fifo #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic do_wr;
    logic do_rd;
    logic full;
    logic empty;

    assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty = (wr_ptr == rd_ptr);
    assign do_wr = wr_valid_in && !full;
    assign do_rd = rd_ready_in && !empty;
    assign wr_ready_out = !full;
    assign rd_valid_out = !empty;
    assign rd_data_out = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge ref_clk_in) begin
        if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= wr_data_in;
        end
        if (rst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    fifo_no_overflow_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        full |-> ##1 (wr_ptr == $past(wr_ptr)))
        else $error("FIFO pointer moved while full");
endmodule : pixel_fifo

// ### lvds_test_pattern_generator.sv
// Test pattern generator feeding the serializer input through a FIFO
//
// Contract
// - Fixed mode: 6 high, 8 low bits.
// - Horizontal gradient: start, hold pitch, add step.
// - Ramp runs to maximum then restarts.
// - Vertical gradient advances once every pitch lines.
// - Lattice: step on grid, value elsewhere.
// - Stripes alternate step and value codes.
// - Sync link test starts at line edge.
// - Async link test starts without line edge.
// - Link test code: 8 high, 8 low. The code keeps only the low 14 bits, so 6 high bits reach the word.
// - Pseudo random from x14+x13+x11+x9+1.
// - Pseudo random waits for line edge.
// - Three bit field selects pattern type.
// - Minimum code start period, then valid region.
// - Pattern starts at next line edge.
`timescale 1ns/1ps
module lvds_test_pattern_generator
    import tpg_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic pixel_en_in,
    input wire logic line_start_pulse_in,
    input wire logic test_mode_in,
    input wire logic pattern_en_in,
    input wire logic prbs_en_in,
    input wire logic [2:0] pattern_sel_in,
    input wire logic [7:0] value_hi_in,
    input wire logic [7:0] value_lo_in,
    input wire logic [13:0] step_in,
    input wire logic [15:0] pitch_in,
    input wire logic [15:0] start_len_in,
    input wire logic [15:0] width_in,
    input wire logic [13:0] adc_ch1_in,
    input wire logic [13:0] adc_ch2_in,
    output logic [13:0] ser_ch1_out,
    output logic [13:0] ser_ch2_out,
    output logic ser_valid_out,
    input wire logic ser_ready_in,
    output logic active_out,
    output logic stall_out
);
    typedef struct packed {
        gen_state_t st;
        logic [2:0] sync;
        logic line_prev;
        logic [15:0] px;
        logic [15:0] ln_cnt;
        logic [15:0] hold;
        logic [13:0] hval;
        logic [15:0] vhold;
        logic [13:0] vval;
        logic [13:0] lfsr;
        logic prbs_mode;
        logic [13:0] word;
        logic word_vld;
        logic [27:0] out_data;
        logic out_valid;
        logic active;
        logic stall;
    } gen_reg_t;

    gen_reg_t r;
    gen_reg_t next_r;
    logic line_edge;
    logic enabled;
    logic fifo_wr_ready;
    logic [27:0] fifo_rd_data;
    logic fifo_rd_valid;
    logic fifo_rd_ready;
    pixel_pair_t fifo_in;

    function automatic logic [13:0] lfsr_step(input logic [13:0] s);
        lfsr_step = {s[12:0], ^(s & LFSR_TAPS)};
    endfunction : lfsr_step

    // Saturating add keeps the ramp from wrapping past the top code
    function automatic logic [13:0] ramp_next(input logic [13:0] v, input logic [13:0] st);
        logic [14:0] sum;
        sum = {1'b0, v} + {1'b0, st};
        ramp_next = sum[14] ? MAX_CODE : sum[13:0];
    endfunction : ramp_next

    function automatic logic [13:0] fixed_code(input logic [7:0] hi, input logic [7:0] lo);
        fixed_code = {hi[HI_FIXED_W-1:0], lo};
    endfunction : fixed_code

    function automatic logic [13:0] link_code(input logic [7:0] hi, input logic [7:0] lo);
        logic [15:0] w;
        w = {hi[HI_LINK_W-1:0], lo};
        link_code = w[13:0];
    endfunction : link_code

    // Pin is asynchronous: three stages, edge counts once stages two and three agree
    assign line_edge = r.sync[1] && r.sync[2] && !r.line_prev;
    assign enabled = test_mode_in && (pattern_en_in || prbs_en_in);

    always_comb begin
        logic [13:0] pat;
        logic in_valid;
        logic grid_hit;
        logic [15:0] pel;
        pat = MIN_CODE;
        in_valid = 1'b0;
        grid_hit = 1'b0;
        pel = 16'h0000;
        next_r = r;
        next_r.sync = {r.sync[1:0], line_start_pulse_in};
        next_r.word_vld = 1'b0;
        if (r.sync[1] == r.sync[2]) begin
            next_r.line_prev = r.sync[2];
        end
        next_r.stall = !fifo_wr_ready;
        if (!enabled) begin
            next_r.st = ST_IDLE;
        end
        case (r.st)
            ST_IDLE: begin
                if (enabled) begin
                    next_r.prbs_mode = prbs_en_in;
                    next_r.lfsr = {value_hi_in[5:0], value_lo_in};
                    next_r.hval = {value_hi_in[5:0], value_lo_in};
                    next_r.vval = {value_hi_in[5:0], value_lo_in};
                    next_r.hold = 16'h0000;
                    next_r.vhold = 16'h0000;
                    next_r.ln_cnt = 16'h0000;
                    next_r.px = 16'h0000;
                    if (!prbs_en_in && pattern_sel_in == MODE_LINK_ASYNC) begin
                        next_r.st = ST_RUN;
                    end else begin
                        next_r.st = ST_WAIT_LINE;
                    end
                end
            end
            ST_WAIT_LINE: begin
                if (line_edge && enabled) begin
                    next_r.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (line_edge) begin
                    next_r.px = 16'h0000;
                    next_r.ln_cnt = r.ln_cnt + 16'h0001;
                    next_r.hold = 16'h0000;
                    next_r.hval = {value_hi_in[5:0], value_lo_in};
                    if (r.vhold + 16'h0001 >= pitch_in) begin
                        next_r.vhold = 16'h0000;
                        next_r.vval = (r.vval == MAX_CODE) ? {value_hi_in[5:0], value_lo_in}
                                                           : ramp_next(r.vval, step_in);
                    end else begin
                        next_r.vhold = r.vhold + 16'h0001;
                    end
                end else if (pixel_en_in && fifo_wr_ready) begin
                    next_r.word_vld = 1'b1;
                    next_r.px = r.px + 16'h0001;
                    in_valid = (r.px >= start_len_in) &&
                               ({1'b0, r.px} < {1'b0, start_len_in} + {1'b0, width_in});
                    pel = r.px - start_len_in;
                    grid_hit = (pitch_in != 16'h0000) &&
                               ((pel % pitch_in == 16'h0000) || (r.ln_cnt % pitch_in == 16'h0000));
                    if (in_valid) begin
                        if (r.hold + 16'h0001 >= pitch_in) begin
                            next_r.hold = 16'h0000;
                            next_r.hval = (r.hval == MAX_CODE) ? {value_hi_in[5:0], value_lo_in}
                                                               : ramp_next(r.hval, step_in);
                        end else begin
                            next_r.hold = r.hold + 16'h0001;
                        end
                    end
                    if (r.prbs_mode) begin
                        pat = r.lfsr;
                        next_r.lfsr = lfsr_step(r.lfsr);
                    end else begin
                        case (pattern_mode_t'(pattern_sel_in))
                            MODE_FIXED: pat = fixed_code(value_hi_in, value_lo_in);
                            MODE_HGRAD: pat = r.hval;
                            MODE_VGRAD: pat = r.vval;
                            MODE_LATTICE: pat = grid_hit ? step_in
                                                         : fixed_code(value_hi_in, value_lo_in);
                            MODE_STRIPE: pat = ((pitch_in != 16'h0000) && (pel / pitch_in) % 2 == 1)
                                               ? fixed_code(value_hi_in, value_lo_in) : step_in;
                            // link code built 8 and 8, then cut to the low 14 bits, so 6 high bits remain
                            MODE_LINK_SYNC: pat = link_code(value_hi_in, value_lo_in);
                            MODE_LINK_ASYNC: pat = link_code(value_hi_in, value_lo_in);
                            default: pat = MIN_CODE;
                        endcase
                    end
                    // Link test words ignore the start period and width
                    if (!r.prbs_mode && (pattern_sel_in == MODE_LINK_SYNC ||
                                         pattern_sel_in == MODE_LINK_ASYNC)) begin
                        next_r.word = pat;
                    end else begin
                        next_r.word = in_valid ? pat : MIN_CODE;
                    end
                end
            end
            default: next_r.st = ST_IDLE;
        endcase
        next_r.active = (next_r.st == ST_RUN);
        // Output word stands until the serializer takes it, so none is lost or doubled
        if (fifo_rd_ready) begin
            next_r.out_valid = fifo_rd_valid;
            next_r.out_data = fifo_rd_data;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            r <= '0;
            r.st <= ST_IDLE;
            r.lfsr <= LFSR_RESET;
        end else begin
            r <= next_r;
        end
    end

    always_comb begin
        if (r.active) begin
            fifo_in = {r.word, r.word};
        end else begin
            fifo_in = {adc_ch1_in, adc_ch2_in};
        end
    end

    // Output register drains the FIFO when the serializer accepts or the register holds no valid word
    assign fifo_rd_ready = ser_ready_in || !r.out_valid;

    pixel_fifo #(
        .WIDTH(28),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .wr_data_in(fifo_in),
        .wr_valid_in(r.active ? r.word_vld : pixel_en_in),
        .wr_ready_out(fifo_wr_ready),
        .rd_data_out(fifo_rd_data),
        .rd_valid_out(fifo_rd_valid),
        .rd_ready_in(fifo_rd_ready)
    );

    assign ser_ch1_out = r.out_data[27:14];
    assign ser_ch2_out = r.out_data[13:0];
    assign ser_valid_out = r.out_valid;
    assign active_out = r.active;
    assign stall_out = r.stall;

    start_on_edge_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (r.st == ST_WAIT_LINE && !line_edge && enabled) |=> (r.st != ST_RUN))
        else $error("Pattern started without line edge");
    // async link leaves idle straight to run
    async_start_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (r.st == ST_IDLE && enabled && !prbs_en_in && pattern_sel_in == MODE_LINK_ASYNC)
        |=> (r.st == ST_RUN))
        else $error("Async link test did not start at once");
    prbs_step_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (r.st == ST_RUN && r.prbs_mode && next_r.word_vld && enabled)
        |=> (r.lfsr == lfsr_step($past(r.lfsr))))
        else $error("Pseudo random step wrong");
    start_period_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (r.st == ST_RUN && next_r.word_vld && r.px < start_len_in && !r.prbs_mode &&
         pattern_sel_in < MODE_LINK_SYNC) |=> (r.word == MIN_CODE))
        else $error("Start period not minimum code");
    // valid pixels carry the sequence word
    prbs_word_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (r.st == ST_RUN && r.prbs_mode && next_r.word_vld && enabled && r.px >= start_len_in &&
         {1'b0, r.px} < {1'b0, start_len_in} + {1'b0, width_in})
        |=> (r.word == $past(r.lfsr)))
        else $error("Pseudo random word wrong");
    out_hold_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (r.out_valid && !ser_ready_in) |=> (r.out_valid && $stable(r.out_data)))
        else $error("Serializer word changed before it was taken");
    // a line edge while waiting starts the pattern
    sequence wait_edge_s;
        r.st == ST_WAIT_LINE && line_edge && enabled;
    endsequence
    edge_start_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        wait_edge_s |=> (r.st == ST_RUN && r.active))
        else $error("Pattern did not start on line edge");
endmodule : lvds_test_pattern_generator

// ### pattern_sink.sv
// Capturing-side model that takes pixel words off the serializer input
`timescale 1ns/1ps
module pattern_sink (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [1:0] slow_in,
    input wire logic [13:0] ch1_in,
    input wire logic [13:0] ch2_in,
    input wire logic valid_in,
    output logic ready_out,
    output logic got_out,
    output logic [13:0] got_ch1_out,
    output logic [13:0] got_ch2_out
);
    logic phase;
    // Mode 1 takes every other cycle, mode 2 refuses all so the buffer fills
    assign ready_out = (slow_in == 2'h0) || (slow_in == 2'h1 && phase);
    always_ff @(posedge ref_clk_in) begin
        phase <= rst_in ? 1'b0 : !phase;
        got_out <= !rst_in && valid_in && ready_out;
        got_ch1_out <= ch1_in;
        got_ch2_out <= ch2_in;
    end
endmodule : pattern_sink

// ### lvds_test_pattern_generator_bench.sv
// Self-checking bench for the test pattern generator
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module lvds_test_pattern_generator_bench;
    import tpg_pkg::*;
    logic clk = 0, rst = 1, pix = 0, line = 0, tmode = 0, pen = 0, ren = 0;
    logic [1:0] slow = 0;
    logic [2:0] sel = 0;
    logic [7:0] hi = 0, lo = 0;
    logic [13:0] stp = 0, a1 = 0, a2 = 0, o1, o2, g1, g2, lf = 0;
    logic [15:0] pit = 1, slen = 0, wid = 0;
    logic ov, rdy, act, stl, got;
    int num_errors = 0, compares = 0, cycles = 0, lnum;
    bit prbs, flood;
    logic [31:0] rs = 32'h6;
    logic [27:0] q[$];

    lvds_test_pattern_generator u_dut (.ref_clk_in(clk), .rst_in(rst), .pixel_en_in(pix),
        .line_start_pulse_in(line), .test_mode_in(tmode), .pattern_en_in(pen),
        .prbs_en_in(ren), .pattern_sel_in(sel), .value_hi_in(hi), .value_lo_in(lo),
        .step_in(stp), .pitch_in(pit), .start_len_in(slen), .width_in(wid),
        .adc_ch1_in(a1), .adc_ch2_in(a2), .ser_ch1_out(o1), .ser_ch2_out(o2),
        .ser_valid_out(ov), .ser_ready_in(rdy), .active_out(act), .stall_out(stl));
    pattern_sink u_sink (.ref_clk_in(clk), .rst_in(rst), .slow_in(slow), .ch1_in(o1),
        .ch2_in(o2), .valid_in(ov), .ready_out(rdy), .got_out(got), .got_ch1_out(g1),
        .got_ch2_out(g2));

    initial begin
        forever #5 clk = !clk;
    end

    function void next_rand();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
    endfunction : next_rand

    // Expected word for pixel p of the current line
    function automatic logic [13:0] expw(int p);
        int v, d, k, n;
        v = {hi[5:0], lo};
        d = p - int'(slen);
        if (sel == MODE_LINK_SYNC || sel == MODE_LINK_ASYNC) return 14'({hi, lo});
        if (d < 0 || d >= int'(wid) || sel == MODE_RESERVED) return MIN_CODE;
        if (prbs) return lf;
        case (sel)
            MODE_HGRAD, MODE_VGRAD: begin
                n = ((sel == MODE_HGRAD) ? d : lnum) / int'(pit);
                k = v;
                // saturate at the top code, then restart from the start value
                for (int i = 0; i < n; i++) begin
                    k = (k == 16383) ? v : ((k + int'(stp) > 16383) ? 16383 : k + int'(stp));
                end
            end
            MODE_LATTICE: k = (d % int'(pit) == 0 || lnum % int'(pit) == 0) ? int'(stp) : v;
            MODE_STRIPE: k = ((d / int'(pit)) % 2 == 0) ? int'(stp) : v;
            default: k = v;
        endcase
        return k[13:0];
    endfunction : expw

    task end_of_test();
        if (num_errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test

    task tick(int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task drain();
        int guard;
        guard = 0;
        while (q.size() > 0 && guard < 500) begin
            tick(1);
            guard++;
        end
        `CHK(q.size(), 0)
    endtask : drain

    task pixel(int p);
        int guard;
        logic [13:0] w;
        guard = 0;
        // Keep the buffer short of full so no pixel is refused
        while (q.size() > 4 && guard < 200) begin
            tick(1);
            guard++;
        end
        next_rand();
        slow <= {1'b0, rs[0]};
        a1 <= rs[13:0];
        a2 <= rs[27:14];
        pix <= 1;
        w = expw(p);
        // bench copy of the sequence steps on every pixel
        if (prbs) lf = {lf[12:0], lf[13] ^ lf[12] ^ lf[10] ^ lf[8]};
        q.push_back({w, w});
        tick(1);
        pix <= 0;
        tick(1);
    endtask : pixel

    task run(int m);
        pen <= 0;
        ren <= 0;
        tick(4);
        drain();
        prbs = (m == 8);
        next_rand();
        // test mode and parameters before enable
        tmode <= 1;
        tick(1);
        sel <= m[2:0];
        // Run 9 starts the ramp near the top code so it saturates and restarts
        hi <= (m == 9) ? 8'h3f : {4'h0, rs[3:0]};
        lo <= rs[15:8];
        stp <= (m == 9) ? 14'h0100 : {8'h00, rs[21:16]};
        pit <= {14'h0, rs[23:22]} + 16'h2;
        slen <= (m == 0) ? 16'h3 : 16'h0;
        wid <= 16'hc;
        tick(1);
        lf = {hi[5:0], lo};
        pen <= !prbs;
        ren <= prbs;
        lnum = -1;
        tick(4);
        `CHK(act, 1'(m == 6))
        if (m != 6) begin
            // Converter data passes while the generator waits for a line
            next_rand();
            a1 <= rs[13:0];
            a2 <= rs[27:14];
            q.push_back({rs[13:0], rs[27:14]});
            pix <= 1;
            tick(1);
            pix <= 0;
            tick(1);
        end
        for (int l = 0; l < 3; l++) begin
            line <= 1;
            tick(8);
            line <= 0;
            lnum++;
            tick(2);
            `CHK(act, 1'b1)
            for (int p = 0; p < 16; p++) pixel(p);
        end
        if (m == 5) begin
            drain();
            flood = 1;
            slow <= 2'h2;
            for (int i = 0; i < 12; i++) begin
                pix <= 1;
                tick(1);
                pix <= 0;
                tick(1);
            end
            `CHK(stl, 1'b1)
            slow <= 2'h0;
            tick(60);
            flood = 0;
            `CHK(stl, 1'b0)
        end
    endtask : run

    always @(posedge clk) begin
        cycles++;
        if (got) begin
            if (flood) begin
                `CHK(g1, 14'({hi, lo}))
                `CHK(g2, g1)
            end else begin
                `CHK(q.size() != 0, 1'b1)
                if (q.size() != 0) begin
                    if (prbs) `CHK(g1, q[0][27:14])
                    else `CHK(g1, q[0][27:14])
                    `CHK(g2, q[0][13:0])
                    void'(q.pop_front());
                end
            end
        end
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end

    initial begin
        tick(8);
        rst <= 0;
        tick(2);
        `CHK({ov, act, stl}, 3'h0)
        for (int m = 0; m < 10; m++) run(m);
        pen <= 0;
        ren <= 0;
        tick(4);
        drain();
        end_of_test();
    end
endmodule : lvds_test_pattern_generator_bench
